// ---- hdl/ieprio_cfg.svh ----
// Constants of the interrupt enable and priority unit: offsets, field positions, resets.
// Assumes inclusion by bare name from the unit's design files.
`ifndef IEPRIO_CFG_SVH
`define IEPRIO_CFG_SVH

`define IEPRIO_ADDR_ENABLE_LOW     8'hA8
`define IEPRIO_ADDR_PRIORITY_LOW   8'hB8
`define IEPRIO_ADDR_ENABLE_HIGH    8'hE8
`define IEPRIO_ADDR_PRIORITY_HIGH  8'hF8

`define IEPRIO_RESET_BYTE          8'h00

`define IEPRIO_BIT_GLOBAL          7
`define IEPRIO_ENH_GP_PIN          7
`define IEPRIO_ENH_USB             6
`define IEPRIO_ENH_FIFO_SERIAL     5
`define IEPRIO_ENH_TWO_WIRE        4
`define IEPRIO_ENH_CONTACTLESS0    3
`define IEPRIO_ENH_CONTACTLESS1    2
`define IEPRIO_PRH_NUMBER7         0

`define IEPRIO_ENH_WRITE_MASK      8'hFC
`define IEPRIO_PRL_WRITE_MASK      8'h7F
`define IEPRIO_PRH_WRITE_MASK      8'hFD

`define IEPRIO_NUM_SOURCES         15
`define IEPRIO_VECTOR_BASE         16'h0003
`define IEPRIO_VECTOR_STEP         16'h0008
`define IEPRIO_VECTOR_LAST         16'h0073

`endif

// ---- hdl/ieprio_pick.sv ----
// Fixed-rank selector: lowest request number among a vector wins.
// Assumes a purely combinational use by the unit's top module.
`default_nettype none
`include "ieprio_cfg.svh"

module ieprio_pick
(
    input  wire logic [14:0]            i_req,
    output logic                        o_any,
    output ieprio_pkg::ieprio_index_t   o_index
);

    always_comb
    begin
        o_any   = 1'b0;
        o_index = 4'h0;
        for (int k = `IEPRIO_NUM_SOURCES - 1; k >= 0; k--)
        begin
            if (i_req[k])
            begin
                o_any   = 1'b1;
                o_index = 4'(k);
            end
        end
    end

endmodule // ieprio_pick

`default_nettype wire

// ---- hdl/ieprio_pkg.sv ----
// Types shared by the interrupt enable and priority unit.
// Assumes no other package.
`default_nettype none

package ieprio_pkg;

    typedef enum logic [1:0]
    {
        IEPRIO_IDLE,
        IEPRIO_LOW_ACTIVE,
        IEPRIO_HIGH_ACTIVE
    } ieprio_level_t;

    typedef logic [3:0] ieprio_index_t;

endpackage : ieprio_pkg

`default_nettype wire

// ---- hdl/ieprio_top.sv ----
// Interrupt enable and two-level priority unit of the embedded core.
// Assumes the core's special register port and same-clock request lines from peripherals.
//
// Summary of operation
// - Enable high bit 7 gates pin IRQ.
// - Enable high bit 6 gates USB request.
// - Enable high bit 5 gates FIFO/serial request.
// - Enable high bit 4 gates two-wire request.
// - Enable high bit 3 gates contactless line zero.
// - Enable high bit 2 gates contactless line one.
// - Each source has a low/high priority bit.
// - High priority served before low priority.
// - Same level resolved by fixed rank.
// - High preempts low; no same-level nesting.
// - Return resumes after the interrupted point.
// - One instruction runs after return first.
// - Priority low bits 6:0 map core sources.
// - Priority high bits 7:2 map peripherals.
// - Priority high bit 0 raises number 7.
// - Global enable bit 7 masks all sources.
// - Rank follows number; vectors 0003h step 8.
`default_nettype none
`include "ieprio_cfg.svh"

module ieprio_top
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_sfr_addr,
    input  wire logic        i_sfr_wr,
    input  wire logic        i_sfr_rd,
    input  wire logic [7:0]  i_sfr_wdata,
    input  wire logic        i_ext_pin_zero_req,
    input  wire logic        i_timer0_req,
    input  wire logic        i_ext_pin_one_req,
    input  wire logic        i_timer1_req,
    input  wire logic        i_debug_serial_req,
    input  wire logic        i_timer2_req,
    input  wire logic        i_near_field_wired_req,
    input  wire logic        i_contactless_request_one,
    input  wire logic        i_contactless_request_zero,
    input  wire logic        i_two_wire_req,
    input  wire logic        i_fifo_serial_req,
    input  wire logic        i_usb_req,
    input  wire logic        i_gp_pin_req,
    input  wire logic        i_irq_ack,
    input  wire logic        i_return_from_interrupt,
    input  wire logic        i_instr_done,
    output logic [7:0]       o_sfr_rdata,
    output logic             o_irq_req,
    output logic [15:0]      o_irq_vector,
    output logic [3:0]       o_irq_number,
    output logic [1:0]       o_level_in_service
);

    logic [7:0]                 enable_mask_low_reg;
    logic [7:0]                 enable_mask_high_reg;
    logic [7:0]                 priority_select_low_reg;
    logic [7:0]                 priority_select_high_reg;
    ieprio_pkg::ieprio_level_t  level_reg;
    ieprio_pkg::ieprio_level_t  level_next;
    logic                       low_nested_reg;
    logic                       hold_off_reg;
    logic [14:0]                src_req;
    logic [14:0]                src_enable;
    logic [14:0]                src_high;
    logic [14:0]                gated;
    logic [14:0]                req_high;
    logic [14:0]                req_low;
    logic                       any_high;
    logic                       any_low;
    ieprio_pkg::ieprio_index_t  idx_high;
    ieprio_pkg::ieprio_index_t  idx_low;
    logic                       grant_high;
    logic                       grant_low;
    ieprio_pkg::ieprio_index_t  pick_index;

    // Requests, enables and levels ordered by interrupt number.
    assign src_req = {i_gp_pin_req, i_usb_req, i_fifo_serial_req, i_two_wire_req,
                      i_contactless_request_zero, i_contactless_request_one,
                      2'b00, i_near_field_wired_req, i_timer2_req,
                      i_debug_serial_req, i_timer1_req, i_ext_pin_one_req,
                      i_timer0_req, i_ext_pin_zero_req};

    assign src_enable = {enable_mask_high_reg[`IEPRIO_ENH_GP_PIN],
                         enable_mask_high_reg[`IEPRIO_ENH_USB],
                         enable_mask_high_reg[`IEPRIO_ENH_FIFO_SERIAL],
                         enable_mask_high_reg[`IEPRIO_ENH_TWO_WIRE],
                         enable_mask_high_reg[`IEPRIO_ENH_CONTACTLESS0],
                         enable_mask_high_reg[`IEPRIO_ENH_CONTACTLESS1],
                         2'b00, enable_mask_low_reg[6:0]};

    assign src_high = {priority_select_high_reg[7:2],
                       1'b0,
                       priority_select_high_reg[`IEPRIO_PRH_NUMBER7],
                       priority_select_low_reg[6:0]};

    // Global enable masks every source.
    assign gated = enable_mask_low_reg[`IEPRIO_BIT_GLOBAL]
                   ? (src_req & src_enable) : 15'h0000;

    assign req_high = gated & src_high;
    assign req_low  = gated & ~src_high;

    ieprio_pick u_pick_high
    (
        .i_req   (req_high),
        .o_any   (any_high),
        .o_index (idx_high)
    );

    ieprio_pick u_pick_low
    (
        .i_req   (req_low),
        .o_any   (any_low),
        .o_index (idx_low)
    );

    // High may preempt idle or low service; low only from idle.
    assign grant_high = any_high && !hold_off_reg
                        && (level_reg != ieprio_pkg::IEPRIO_HIGH_ACTIVE);
    assign grant_low  = any_low && !any_high && !hold_off_reg
                        && (level_reg == ieprio_pkg::IEPRIO_IDLE);
    assign pick_index = grant_high ? idx_high : idx_low;

    // Register writes; reserved bits stay zero.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            enable_mask_low_reg      <= `IEPRIO_RESET_BYTE;
            enable_mask_high_reg     <= `IEPRIO_RESET_BYTE;
            priority_select_low_reg  <= `IEPRIO_RESET_BYTE;
            priority_select_high_reg <= `IEPRIO_RESET_BYTE;
        end
        else if (i_sfr_wr)
        begin
            if (i_sfr_addr == `IEPRIO_ADDR_ENABLE_LOW)
            begin
                enable_mask_low_reg <= i_sfr_wdata;
            end
            else if (i_sfr_addr == `IEPRIO_ADDR_ENABLE_HIGH)
            begin
                enable_mask_high_reg <= i_sfr_wdata & `IEPRIO_ENH_WRITE_MASK;
            end
            else if (i_sfr_addr == `IEPRIO_ADDR_PRIORITY_LOW)
            begin
                priority_select_low_reg <= i_sfr_wdata & `IEPRIO_PRL_WRITE_MASK;
            end
            else if (i_sfr_addr == `IEPRIO_ADDR_PRIORITY_HIGH)
            begin
                priority_select_high_reg <= i_sfr_wdata & `IEPRIO_PRH_WRITE_MASK;
            end
        end
    end

    // Read data registered one cycle after the read strobe.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_sfr_rdata <= 8'h00;
        end
        else if (i_sfr_rd)
        begin
            if (i_sfr_addr == `IEPRIO_ADDR_ENABLE_LOW)
            begin
                o_sfr_rdata <= enable_mask_low_reg;
            end
            else if (i_sfr_addr == `IEPRIO_ADDR_ENABLE_HIGH)
            begin
                o_sfr_rdata <= enable_mask_high_reg;
            end
            else if (i_sfr_addr == `IEPRIO_ADDR_PRIORITY_LOW)
            begin
                o_sfr_rdata <= priority_select_low_reg;
            end
            else if (i_sfr_addr == `IEPRIO_ADDR_PRIORITY_HIGH)
            begin
                o_sfr_rdata <= priority_select_high_reg;
            end
            else
            begin
                o_sfr_rdata <= 8'h00;
            end
        end
    end

    // Request and vector towards the core, recomputed each cycle except on acknowledge or return, which clear the request and hold number and vector.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_irq_req    <= 1'b0;
            o_irq_number <= 4'h0;
            o_irq_vector <= 16'h0000;
        end
        else if (i_irq_ack || i_return_from_interrupt)
        begin
            o_irq_req <= 1'b0;
        end
        else
        begin
            o_irq_req    <= grant_high || grant_low;
            o_irq_number <= pick_index;
            o_irq_vector <= `IEPRIO_VECTOR_BASE
                            + (`IEPRIO_VECTOR_STEP * {12'h000, pick_index});
        end
    end

    // Level in service, with one low level saved under a high preemption.
    always_comb
    begin
        level_next = level_reg;
        if (i_irq_ack && o_irq_req)
        begin
            if (o_irq_number <= 4'hE && src_high[o_irq_number])
            begin
                level_next = ieprio_pkg::IEPRIO_HIGH_ACTIVE;
            end
            else
            begin
                level_next = ieprio_pkg::IEPRIO_LOW_ACTIVE;
            end
        end
        else if (i_return_from_interrupt)
        begin
            if (level_reg == ieprio_pkg::IEPRIO_HIGH_ACTIVE && low_nested_reg)
            begin
                level_next = ieprio_pkg::IEPRIO_LOW_ACTIVE;
            end
            else
            begin
                level_next = ieprio_pkg::IEPRIO_IDLE;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            level_reg      <= ieprio_pkg::IEPRIO_IDLE;
            low_nested_reg <= 1'b0;
        end
        else
        begin
            level_reg <= level_next;
            if (i_irq_ack && o_irq_req)
            begin
                low_nested_reg <= (level_reg == ieprio_pkg::IEPRIO_LOW_ACTIVE);
            end
            else if (i_return_from_interrupt
                     && level_reg == ieprio_pkg::IEPRIO_HIGH_ACTIVE)
            begin
                low_nested_reg <= 1'b0;
            end
        end
    end

    // After return, hold off until one instruction completes.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            hold_off_reg <= 1'b0;
        end
        else if (i_return_from_interrupt)
        begin
            hold_off_reg <= 1'b1;
        end
        else if (i_instr_done)
        begin
            hold_off_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_level_in_service <= 2'b00;
        end
        else
        begin
            o_level_in_service <= {level_next == ieprio_pkg::IEPRIO_HIGH_ACTIVE,
                                   level_next != ieprio_pkg::IEPRIO_IDLE};
        end
    end

endmodule // ieprio_top

`default_nettype wire

// ---- verif/ieprio_bench.sv ----
// Self-checking bench of the enable and priority unit with a behavioural core.
// Assumes the unit's design files and the checker are compiled first.
`default_nettype none
module ieprio_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clk_sys = 1'b0, i_reset_n = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
    logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, lf = 8'h4C, p0, p1;
    logic [14:0] rq = 15'h0;
    logic        ack_en = 1'b0, ret_cmd = 1'b0, i_irq_ack, i_return_from_interrupt;
    logic        i_instr_done, o_irq_req;
    logic [15:0] o_irq_vector;
    logic [3:0]  o_irq_number;
    logic [1:0]  o_level_in_service;
    logic [7:0]  ad [5] = '{8'hA8, 8'hE8, 8'hB8, 8'hF8, 8'h5A};
    logic [7:0]  mk [5] = '{8'hFF, 8'hFC, 8'h7F, 8'hFD, 8'h00};
    int          mismatches = 0;
    int          num_checks = 0;
    wire i_ext_pin_zero_req = rq[0], i_timer0_req = rq[1], i_ext_pin_one_req = rq[2],
        i_timer1_req = rq[3], i_debug_serial_req = rq[4], i_timer2_req = rq[5],
        i_near_field_wired_req = rq[6], i_contactless_request_one = rq[9],
        i_contactless_request_zero = rq[10], i_two_wire_req = rq[11],
        i_fifo_serial_req = rq[12], i_usb_req = rq[13], i_gp_pin_req = rq[14];
    always #5 i_clk_sys = ~i_clk_sys;
    ieprio_top DUT (.*);
    ieprio_core_model u_core (.i_clk_sys, .i_reset_n, .i_irq_req(o_irq_req), .i_ack_en(ack_en),
        .i_ret_cmd(ret_cmd), .o_ack(i_irq_ack), .o_ret(i_return_from_interrupt),
        .o_done(i_instr_done));
    task automatic tk;
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic bad(input string m);
        mismatches++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task automatic chk_reg(input logic [7:0] e);
        num_checks++;
        if (o_sfr_rdata !== e) bad("register value");
    endtask
    task automatic chk_irq(input logic r, input logic [3:0] n);
        num_checks++;
        if (o_irq_req !== r || (r && (o_irq_number !== n
            || o_irq_vector !== 16'h0003 + {n, 3'h0}))) bad("offer");
    endtask
    task automatic chk_lvl(input logic [1:0] e);
        num_checks++;
        if (o_level_in_service !== e) bad("level");
    endtask
    task automatic wr(input logic [7:0] a, d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        tk;
        i_sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        tk;
        i_sfr_rd = 1'b0;
    endtask
    task automatic rt;
        ret_cmd = 1'b1;
        tk;
        ret_cmd = 1'b0;
    endtask
    task automatic wt(input logic [1:0] l);
        for (int k = 0; k < 20 && o_level_in_service !== l; k++)
            tk;
        chk_lvl(l);
        if (o_level_in_service !== l) test_done;
    endtask
    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [3:0] pick(input logic [14:0] g, input logic [7:0] a, b);
        logic [14:0] h;
        h = g & {b[7:2], 1'b0, b[0], a[6:0]};
        if (h == 15'h0) h = g;
        pick = 4'h0;
        for (int i = 14; i >= 0; i--)
            if (h[i]) pick = 4'(i);
    endfunction
    initial
    begin
        repeat (12) tk;
        i_reset_n = 1'b1;
        tk;
        for (int i = 0; i < 5; i++)
        begin
            rd(ad[i]);
            chk_reg(8'h00);
            wr(ad[i], 8'hFF);
            rd(ad[i]);
            chk_reg(mk[i]);
        end
        $display("register test done");
        wr(8'hB8, 8'h00);
        wr(8'hF8, 8'h00);
        for (int n = 0; n < 15; n++)
        begin
            if (n == 7 || n == 8) continue;
            p0 = n < 7 ? 8'h80 | (8'h01 << n) : 8'h80;
            wr(8'hA8, p0);
            wr(8'hE8, n > 8 ? 8'h01 << (n - 7) : 8'h00);
            rq = 15'h1 << n;
            tk;
            chk_irq(1'b1, 4'(n));
            wr(8'hA8, p0 & 8'h7F);
            tk;
            chk_irq(1'b0, 4'h0);
            wr(8'hA8, 8'h80);
            wr(8'hE8, 8'h00);
            tk;
            chk_irq(1'b0, 4'h0);
            rq = 15'h0;
        end
        $display("enable test done");
        wr(8'hA8, 8'hFF);
        wr(8'hE8, 8'hFC);
        for (int i = 0; i < 24; i++)
        begin
            lf = nx(lf);
            p0 = lf;
            lf = nx(lf);
            p1 = lf;
            lf = nx(lf);
            rq = 15'({lf, p0 ^ p1}) & 15'h7E7F;
            if (i < 2)
            begin
                rq = 15'h7E7F;
                p0 = 8'h00;
                p1 = i ? 8'h80 : 8'h00;
            end
            wr(8'hB8, p0);
            wr(8'hF8, p1);
            tk;
            chk_irq(rq != 15'h0, pick(rq, p0, p1));
            rq = 15'h0;
        end
        $display("priority test done");
        wr(8'hB8, 8'h00);
        wr(8'hF8, 8'h10);
        ack_en = 1'b1;
        rq = 15'h2000;
        wt(2'h1);
        rq = 15'h2800;
        wt(2'h3);
        ack_en = 1'b0;
        repeat (3) tk;
        chk_irq(1'b0, 4'h0);
        rt;
        wt(2'h1);
        tk;
        chk_irq(1'b0, 4'h0);
        for (int k = 0; k < 20 && o_irq_req !== 1'b1; k++)
            tk;
        chk_irq(1'b1, 4'hB);
        if (o_irq_req !== 1'b1) test_done;
        ack_en = 1'b1;
        wt(2'h3);
        rq = 15'h0;
        ack_en = 1'b0;
        rt;
        wt(2'h1);
        rt;
        wt(2'h0);
        $display("nesting test done");
        test_done;
    end
endmodule // ieprio_bench
`default_nettype wire

// ---- verif/ieprio_core_model.sv ----
// Behavioural core beside the unit: takes offers, returns, completes instructions.
// Assumes the bench enables taking and commands each return.
`default_nettype none
module ieprio_core_model
(
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_irq_req,
    input  wire logic i_ack_en,
    input  wire logic i_ret_cmd,
    output logic      o_ack,
    output logic      o_ret,
    output logic      o_done
);
    logic [1:0] wait_reg;
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_ack <= 1'b0;
            o_ret <= 1'b0;
            o_done <= 1'b0;
            wait_reg <= 2'h0;
        end
        else
        begin
            o_ack <= i_ack_en & i_irq_req & !o_ack;
            o_ret <= i_ret_cmd;
            o_done <= wait_reg == 2'h1;
            wait_reg <= o_ret ? 2'h3 : wait_reg - {1'b0, wait_reg != 2'h0};
        end
    end
endmodule // ieprio_core_model
`default_nettype wire

// ---- verif/ieprio_monitor.sv ----
// Checker of the enable and priority unit.
// Assumes it is bound to the unit's top and sees only its ports.
`default_nettype none
module ieprio_monitor
(
    input wire logic        i_clk_sys, i_reset_n, i_sfr_wr,
    input wire logic [7:0]  i_sfr_addr, i_sfr_wdata,
    input wire logic        i_ext_pin_zero_req, i_timer0_req, i_ext_pin_one_req,
    input wire logic        i_timer1_req, i_debug_serial_req, i_timer2_req,
    input wire logic        i_near_field_wired_req, i_contactless_request_one,
    input wire logic        i_contactless_request_zero, i_two_wire_req,
    input wire logic        i_fifo_serial_req, i_usb_req, i_gp_pin_req,
    input wire logic        i_irq_ack, i_return_from_interrupt, i_instr_done, o_irq_req,
    input wire logic [15:0] o_irq_vector,
    input wire logic [3:0]  o_irq_number,
    input wire logic [1:0]  o_level_in_service
);
    logic [7:0]  enl_reg, enh_reg, prl_reg, prh_reg;
    logic [14:0] gate_reg, prv_reg;
    logic        hold_reg;
    wire  [14:0] rq = {i_gp_pin_req, i_usb_req, i_fifo_serial_req, i_two_wire_req,
        i_contactless_request_zero, i_contactless_request_one, 2'h0, i_near_field_wired_req,
        i_timer2_req, i_debug_serial_req, i_timer1_req, i_ext_pin_one_req, i_timer0_req,
        i_ext_pin_zero_req};
    wire  [14:0] prv = {prh_reg[7:2], 1'b0, prh_reg[0], prl_reg[6:0]};
    wire  [14:0] hig = gate_reg & prv_reg;
    wire         ack_hi = prv[o_irq_number];
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            {enl_reg, enh_reg, prl_reg, prh_reg} <= 32'h0;
        else if (i_sfr_wr)
        begin
            if (i_sfr_addr == 8'hA8) enl_reg <= i_sfr_wdata;
            if (i_sfr_addr == 8'hE8) enh_reg <= i_sfr_wdata & 8'hFC;
            if (i_sfr_addr == 8'hB8) prl_reg <= i_sfr_wdata & 8'h7F;
            if (i_sfr_addr == 8'hF8) prh_reg <= i_sfr_wdata & 8'hFD;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            gate_reg <= 15'h0;
            prv_reg <= 15'h0;
            hold_reg <= 1'b0;
        end
        else
        begin
            gate_reg <= rq & {enh_reg[7:2], 2'h0, enl_reg[6:0]} & {15{enl_reg[7]}};
            prv_reg <= prv;
            hold_reg <= i_return_from_interrupt | (hold_reg & !i_instr_done);
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_take;
        o_irq_req && i_irq_ack;
    endsequence
    sequence s_after_return;
        hold_reg [*2];
    endsequence
    AST_GLOBAL_MASK: assert property ($rose(o_irq_req) |-> $past(enl_reg[7]))
        else $error("offer raised while global enable was off");
    AST_ENABLE_GATE: assert property (o_irq_req |-> gate_reg[o_irq_number])
        else $error("offer without an enabled request");
    AST_VECTOR: assert property (o_irq_req |-> o_irq_vector == 16'h0003 + {o_irq_number, 3'h0})
        else $error("vector does not match number");
    AST_LEVEL_FIRST: assert property (o_irq_req |-> prv_reg[o_irq_number] == (hig != 15'h0))
        else $error("low offered over high");
    AST_RANK: assert property (o_irq_req |-> ((prv_reg[o_irq_number] ? hig : gate_reg)
        & ((15'h1 << o_irq_number) - 15'h1)) == 15'h0)
        else $error("lower rank chosen");
    AST_HIGH_ALONE: assert property (o_level_in_service[1] |-> !o_irq_req)
        else $error("offer during high service");
    AST_LOW_BLOCK: assert property (o_level_in_service == 2'h1 && o_irq_req
        |-> prv_reg[o_irq_number]) else $error("low offered during low service");
    AST_HOLDOFF: assert property (s_after_return |-> !o_irq_req)
        else $error("offer before an instruction after return");
    AST_ACK_LEVEL: assert property (s_take |=> !o_irq_req && o_level_in_service == {$past(ack_hi), 1'b1})
        else $error("level after take wrong");
    AST_RET_IDLE: assert property (i_return_from_interrupt && o_level_in_service == 2'h1
        |=> o_level_in_service == 2'h0) else $error("return left level");
endmodule // ieprio_monitor
bind ieprio_top ieprio_monitor u_mon (.*);
`default_nettype wire
